// ---- rtl/adcs_decim.sv ----
// Bitstream decimator turning modulator bits into one 12-bit code
`timescale 1ns/100ps
module adcs_decim (
	input wire logic clk,
	input wire logic reset,
	input wire logic start,
	input wire logic mod_tick,
	input wire logic mod_bit,
	input wire logic [2:0] rate,
	output logic done,
	output logic [11:0] code
);

	// ************************************************************
	// State
	// ************************************************************
	logic busy_reg, busy_next; // Conversion running
	logic [10:0] ticks_reg, ticks_next; // Modulator periods left
	logic signed [12:0] acc_reg, acc_next; // Ones minus zeros so far
	logic [2:0] rate_reg, rate_next; // Rate frozen for this conversion
	logic done_reg, done_next; // One-cycle completion pulse
	logic [11:0] code_reg, code_next; // Last finished code

	// ************************************************************
	// Next state
	// ************************************************************
	// Settings are frozen at start so a config write never bends a running conversion
	always_comb begin
		logic signed [12:0] acc_step;
		logic signed [34:0] product;
		logic signed [18:0] scaled;
		acc_step = acc_reg + (mod_bit ? 13'sh1 : -13'sh1);
		product = 35'(acc_step) * $signed({1'b0, adcs_pkg::rate_gain(rate_reg)});
		scaled = 19'(product >>> 16);
		busy_next = busy_reg;
		ticks_next = ticks_reg;
		acc_next = acc_reg;
		rate_next = rate_reg;
		done_next = 1'b0;
		code_next = code_reg;
		if (start) begin
			busy_next = 1'b1;
			ticks_next = adcs_pkg::rate_ticks(rate);
			acc_next = 13'sh0;
			rate_next = rate;
		end else if (busy_reg && mod_tick) begin
			acc_next = acc_step;
			ticks_next = ticks_reg - 11'h1;
			// Single-cycle settling: one window of 1/rate per code
			if (ticks_reg == 11'h1) begin
				busy_next = 1'b0;
				done_next = 1'b1;
				// Saturate, the balance can just touch plus full scale
				if (scaled > 19'sd2047) begin
					code_next = 12'h7ff;
				end else if (scaled < -19'sd2048) begin
					code_next = 12'h800;
				end else begin
					code_next = scaled[11:0];
				end
			end
		end
	end

	// Registers only
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			busy_reg <= 1'b0;
			ticks_reg <= 11'h0;
			acc_reg <= 13'sh0;
			rate_reg <= 3'h0;
			done_reg <= 1'b0;
			code_reg <= 12'h0;
		end else begin
			busy_reg <= busy_next;
			ticks_reg <= ticks_next;
			acc_reg <= acc_next;
			rate_reg <= rate_next;
			done_reg <= done_next;
			code_reg <= code_next;
		end
	end

	assign done = done_reg;
	assign code = code_reg;

endmodule

// ---- rtl/adcs_pkg.sv ----
// Shared constants, types and helper functions for the conversion sequencer
package adcs_pkg;

	// ************************************************************
	// Clocking and timing
	// ************************************************************
	localparam int CLK_FREQ_HZ = 100_000_000; // System clock
	localparam int OSC_FREQ_HZ = 1_000_000; // Internal oscillator rate
	localparam int MOD_DIV = 4; // Oscillator to modulator divider
	localparam int MOD_FREQ_HZ = OSC_FREQ_HZ / MOD_DIV; // 250 kHz
	localparam int MOD_TICK_CYCLES = CLK_FREQ_HZ / MOD_FREQ_HZ; // Cycles per modulator period
	localparam int MOD_HALF_CYCLES = MOD_TICK_CYCLES / 2; // High phase of the modulator clock
	localparam int POWER_UP_TIME_NS = 25_000; // Analog wake-up time
	localparam int POWER_UP_CYCLES = (POWER_UP_TIME_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000;

	// ************************************************************
	// Widths and register map
	// ************************************************************
	localparam int CODE_WIDTH = 12; // Result code width
	localparam int ADDR_WIDTH = 4; // Register port address width
	localparam int DATA_WIDTH = 16; // Register port data width
	localparam logic [3:0] CONFIG_OFFSET = 4'h0; // Configuration register
	localparam logic [3:0] RESULT_OFFSET = 4'h4; // Latest conversion code
	localparam logic [3:0] STATUS_OFFSET = 4'h8; // Sticky event bits
	localparam logic [3:0] MASK_OFFSET = 4'hc; // Interrupt mask
	localparam int TRIGGER_BIT = 15; // Conversion trigger flag
	localparam int SELECT_LSB = 12; // Input select field, three bits
	localparam int MODE_BIT = 8; // One selects single-shot
	localparam int RATE_LSB = 5; // Rate select field, three bits
	localparam int DONE_BIT = 0; // Conversion done event
	localparam logic MODE_RESET = 1'b1; // Powered down, single-shot
	localparam logic [2:0] RATE_RESET = 3'h4; // 1600 samples per second
	localparam logic [2:0] SELECT_RESET = 3'h0; // Input 0 against input 1
	localparam logic MASK_RESET = 1'b0; // Interrupt masked off

	// ************************************************************
	// Input routing
	// ************************************************************
	localparam logic [1:0] AIN_0 = 2'h0; // Analog input 0
	localparam logic [1:0] AIN_1 = 2'h1; // Analog input 1
	localparam logic [1:0] AIN_2 = 2'h2; // Analog input 2
	localparam logic [1:0] AIN_3 = 2'h3; // Analog input 3
	localparam logic [2:0] SEL_0_1 = 3'h0; // Input 0 minus input 1
	localparam logic [2:0] SEL_0_3 = 3'h1; // Input 0 minus input 3
	localparam logic [2:0] SEL_1_3 = 3'h2; // Input 1 minus input 3
	localparam logic [2:0] SEL_2_3 = 3'h3; // Input 2 minus input 3

	// Switch settings handed to the analog multiplexer
	typedef struct packed {
		logic [1:0] positive_input;
		logic [1:0] negative_input;
		logic neg_grounded;
	} adcs_route_type;

	// Software-visible configuration
	typedef struct packed {
		logic single_shot;
		logic [2:0] rate_select_field;
		logic [2:0] input_select_field;
	} adcs_config_type;

	// Data rates in samples per second, by rate code
	localparam int RATE_SPS [0:7] = '{128, 250, 490, 920, 1600, 2400, 3300, 3300};
	localparam int CODE_SCALE = 2048 * 65536; // Full scale in 16-bit fixed point

	// ************************************************************
	// Functions
	// ************************************************************
	// Modulator periods in one conversion
	function automatic logic [10:0] rate_ticks(input logic [2:0] rate);
		logic [10:0] t;
		t = 11'h0;
		for (int i = 0; i < 8; i++) begin
			if (rate == 3'(i)) begin
				t = 11'(MOD_FREQ_HZ / RATE_SPS[i]);
			end
		end
		return t;
	endfunction

	// Fixed-point gain mapping a bit balance to a 12-bit code
	function automatic logic [21:0] rate_gain(input logic [2:0] rate);
		logic [21:0] g;
		int n;
		g = 22'h0;
		for (int i = 0; i < 8; i++) begin
			n = MOD_FREQ_HZ / RATE_SPS[i];
			if (rate == 3'(i)) begin
				g = 22'((CODE_SCALE + n / 2) / n);
			end
		end
		return g;
	endfunction

	// Multiplexer switches for a select code
	function automatic adcs_route_type decode_route(input logic [2:0] sel, input logic has_mux);
		adcs_route_type r;
		r = '{positive_input: AIN_0, negative_input: AIN_1, neg_grounded: 1'b0};
		if (has_mux) begin
			unique case (sel)
				SEL_0_1: r = '{positive_input: AIN_0, negative_input: AIN_1, neg_grounded: 1'b0};
				SEL_0_3: r = '{positive_input: AIN_0, negative_input: AIN_3, neg_grounded: 1'b0};
				SEL_1_3: r = '{positive_input: AIN_1, negative_input: AIN_3, neg_grounded: 1'b0};
				SEL_2_3: r = '{positive_input: AIN_2, negative_input: AIN_3, neg_grounded: 1'b0};
				default: r = '{positive_input: sel[1:0], negative_input: AIN_0, neg_grounded: 1'b1};
			endcase
		end
		return r;
	endfunction

endpackage

// ---- rtl/adcs_sequencer.sv ----
// Conversion sequencer top: registers, mode control, routing and modulator clock
// Functional notes
// - Convert differential input to 12-bit code
// - Single-shot: one conversion, store, power down
// - Continuous: restart right after each conversion
// - Continuous rate equals programmed data rate
// - Result readable anytime, holds latest code
// - Three-bit select: four single, four differential
// - Inputs 0, 1 and 2 against input 3
// - Single-ended grounds the negative input
// - Modulator clock is oscillator divided by four
// - No mux: input 0 positive, input 1 negative
// - Trigger flag starts, clears, sets when ready
// - Mode bit zero continuous, one single-shot
// - Conversion time equals one over rate
// - Running conversion keeps old settings
`timescale 1ns/100ps
module adcs_sequencer #(
	parameter bit HAS_MUX = 1'b1
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [3:0] addr,
	input wire logic [15:0] wr_data,
	input wire logic wr_strobe,
	input wire logic rd_strobe,
	output logic [15:0] rd_data,
	input wire logic mod_bit,
	output logic modulator_clock,
	output logic analog_power,
	output adcs_pkg::adcs_route_type route,
	output logic irq
);

	// ************************************************************
	// Declarations
	// ************************************************************
	typedef enum logic [1:0] {ST_POWER_DOWN, ST_POWER_UP, ST_CONVERT} adcs_state_type;

	adcs_state_type state_reg, state_next; // Sequencer state
	logic [11:0] wait_cnt_reg, wait_cnt_next; // Power-up delay counter
	logic [8:0] div_cnt_reg, div_cnt_next; // Modulator period counter
	logic mod_clk_reg, mod_clk_next; // Modulator clock out
	logic sync1_reg, sync2_reg, sync3_reg; // Bitstream synchroniser
	logic bit_reg, bit_next; // Settled modulator bit
	adcs_pkg::adcs_config_type cfg_reg, cfg_next; // Software configuration
	adcs_pkg::adcs_route_type route_reg, route_next; // Switches of the running conversion
	logic [11:0] result_reg, result_next; // Latest code
	logic status_reg, status_next; // Done event, sticky
	logic mask_reg, mask_next; // Done interrupt enable
	logic irq_reg, irq_next; // Interrupt out
	logic [15:0] rd_data_reg, rd_data_next; // Read answer
	logic power_reg, power_next; // Analog core enable
	logic conv_start; // Start pulse to decimator
	logic conv_done; // Code ready pulse
	logic [11:0] conv_code; // Code from decimator
	logic mod_tick; // One cycle per modulator period
	logic cfg_write; // Write to configuration
	logic trig_req; // Trigger flag written with one

	assign cfg_write = wr_strobe && (addr == adcs_pkg::CONFIG_OFFSET);
	assign trig_req = cfg_write && wr_data[adcs_pkg::TRIGGER_BIT];
	assign mod_tick = (div_cnt_reg == 9'(adcs_pkg::MOD_TICK_CYCLES - 1));

	// ************************************************************
	// Modulator clock and bitstream input
	// ************************************************************
	// Free-running divider, the oscillator never stops
	always_comb begin
		div_cnt_next = mod_tick ? 9'h0 : div_cnt_reg + 9'h1;
		mod_clk_next = (div_cnt_next < 9'(adcs_pkg::MOD_HALF_CYCLES));
		// Take a new level only once the last two stages agree
		bit_next = (sync2_reg == sync3_reg) ? sync3_reg : bit_reg;
	end

	// Divider, synchroniser and filtered bit
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			// Parked on the last count so the first rise of the clock lines up with a zero count
			div_cnt_reg <= 9'(adcs_pkg::MOD_TICK_CYCLES - 1);
			mod_clk_reg <= 1'b0;
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			sync3_reg <= 1'b0;
			bit_reg <= 1'b0;
		end else begin
			div_cnt_reg <= div_cnt_next;
			mod_clk_reg <= mod_clk_next;
			sync1_reg <= mod_bit;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			bit_reg <= bit_next;
		end
	end

	// ************************************************************
	// Decimation filter
	// ************************************************************
	adcs_decim u_decim (
		.clk(clk),
		.reset(reset),
		.start(conv_start),
		.mod_tick(mod_tick),
		.mod_bit(bit_reg),
		.rate(cfg_reg.rate_select_field),
		.done(conv_done),
		.code(conv_code)
	);

	// ************************************************************
	// Sequencer
	// ************************************************************
	// Power-down until asked, wake-up delay, then one or many conversions
	always_comb begin
		state_next = state_reg;
		wait_cnt_next = wait_cnt_reg;
		route_next = route_reg;
		conv_start = 1'b0;
		unique case (state_reg)
			ST_POWER_DOWN: begin
				// Continuous mode needs no request; single-shot waits for the flag
				if (!cfg_reg.single_shot || trig_req) begin
					state_next = ST_POWER_UP;
					wait_cnt_next = 12'h0;
				end
			end
			ST_POWER_UP: begin
				if (wait_cnt_reg == 12'(adcs_pkg::POWER_UP_CYCLES - 1)) begin
					state_next = ST_CONVERT;
					conv_start = 1'b1;
					route_next = adcs_pkg::decode_route(cfg_reg.input_select_field, HAS_MUX);
				end else begin
					wait_cnt_next = wait_cnt_reg + 12'h1;
				end
			end
			ST_CONVERT: begin
				// Trigger writes are ignored here
				if (conv_done) begin
					if (cfg_reg.single_shot) begin
						state_next = ST_POWER_DOWN;
					end else begin
						// New settings picked up only at this boundary
						conv_start = 1'b1;
						route_next = adcs_pkg::decode_route(cfg_reg.input_select_field, HAS_MUX);
					end
				end
			end
		endcase
		power_next = (state_next != ST_POWER_DOWN);
	end

	// Sequencer registers; routing defaults to input 0 against input 1
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_reg <= ST_POWER_DOWN;
			wait_cnt_reg <= 12'h0;
			route_reg <= '{positive_input: adcs_pkg::AIN_0, negative_input: adcs_pkg::AIN_1, neg_grounded: 1'b0};
			power_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			wait_cnt_reg <= wait_cnt_next;
			route_reg <= route_next;
			power_reg <= power_next;
		end
	end

	// ************************************************************
	// Register file and interrupt
	// ************************************************************
	// Writes, reads, sticky status and the level interrupt
	always_comb begin
		cfg_next = cfg_reg;
		mask_next = mask_reg;
		status_next = status_reg;
		result_next = result_reg;
		rd_data_next = 16'h0;
		if (cfg_write) begin
			cfg_next.single_shot = wr_data[adcs_pkg::MODE_BIT];
			cfg_next.rate_select_field = wr_data[adcs_pkg::RATE_LSB +: 3];
			cfg_next.input_select_field = wr_data[adcs_pkg::SELECT_LSB +: 3];
		end
		if (wr_strobe && addr == adcs_pkg::MASK_OFFSET) begin
			mask_next = wr_data[adcs_pkg::DONE_BIT];
		end
		// Write one clears, but a same-cycle event wins
		if (wr_strobe && addr == adcs_pkg::STATUS_OFFSET && wr_data[adcs_pkg::DONE_BIT]) begin
			status_next = 1'b0;
		end
		if (conv_done) begin
			status_next = 1'b1;
			result_next = conv_code;
		end
		if (rd_strobe) begin
			unique case (addr)
				adcs_pkg::CONFIG_OFFSET: begin
					rd_data_next[adcs_pkg::TRIGGER_BIT] = (state_reg == ST_POWER_DOWN);
					rd_data_next[adcs_pkg::SELECT_LSB +: 3] = cfg_reg.input_select_field;
					rd_data_next[adcs_pkg::MODE_BIT] = cfg_reg.single_shot;
					rd_data_next[adcs_pkg::RATE_LSB +: 3] = cfg_reg.rate_select_field;
				end
				adcs_pkg::RESULT_OFFSET: rd_data_next[11:0] = result_reg;
				adcs_pkg::STATUS_OFFSET: rd_data_next[adcs_pkg::DONE_BIT] = status_reg;
				adcs_pkg::MASK_OFFSET: rd_data_next[adcs_pkg::DONE_BIT] = mask_reg;
				default: rd_data_next = 16'h0;
			endcase
		end
		irq_next = status_next && mask_next;
	end

	// Register file storage
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cfg_reg <= '{single_shot: adcs_pkg::MODE_RESET, rate_select_field: adcs_pkg::RATE_RESET,
				input_select_field: adcs_pkg::SELECT_RESET};
			mask_reg <= adcs_pkg::MASK_RESET;
			status_reg <= 1'b0;
			result_reg <= 12'h0;
			rd_data_reg <= 16'h0;
			irq_reg <= 1'b0;
		end else begin
			cfg_reg <= cfg_next;
			mask_reg <= mask_next;
			status_reg <= status_next;
			result_reg <= result_next;
			rd_data_reg <= rd_data_next;
			irq_reg <= irq_next;
		end
	end

	assign rd_data = rd_data_reg;
	assign modulator_clock = mod_clk_reg;
	assign analog_power = power_reg;
	assign route = route_reg;
	assign irq = irq_reg;

	// ************************************************************
	// Checks
	// ************************************************************
	// Helper: spacing between completions and whether the last one restarted
	logic [19:0] gap_cnt_reg;
	logic chain_reg;
	logic [2:0] active_rate_reg;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			gap_cnt_reg <= 20'h0;
			chain_reg <= 1'b0;
			active_rate_reg <= 3'h0;
		end else begin
			gap_cnt_reg <= conv_done ? 20'h0 : gap_cnt_reg + 20'h1;
			chain_reg <= conv_done ? !cfg_reg.single_shot : chain_reg;
			active_rate_reg <= conv_start ? cfg_reg.rate_select_field : active_rate_reg;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	a_single_power_down: assert property ((state_reg == ST_CONVERT) && conv_done && cfg_reg.single_shot
		|=> (state_reg == ST_POWER_DOWN) && !power_reg) else $error("single-shot did not power down");
	a_continuous_restart: assert property (conv_done && !cfg_reg.single_shot
		|-> conv_start ##1 (state_reg == ST_CONVERT)) else $error("continuous mode did not restart");
	a_rate_spacing: assert property (conv_done && chain_reg
		|-> gap_cnt_reg == 20'(adcs_pkg::rate_ticks(active_rate_reg) * adcs_pkg::MOD_TICK_CYCLES - 1))
		else $error("continuous conversion period wrong");
	a_result_capture: assert property (conv_done |=> result_reg == $past(conv_code))
		else $error("result not captured at completion");
	a_result_hold: assert property (!conv_done |=> $stable(result_reg))
		else $error("result changed without a completion");
	a_route_at_start: assert property (conv_start
		|=> route_reg == adcs_pkg::decode_route($past(cfg_reg.input_select_field), HAS_MUX))
		else $error("routing not taken at conversion start");
	a_route_frozen: assert property (!conv_start |=> $stable(route_reg))
		else $error("routing changed during a conversion");
	a_trigger_ignored: assert property ((state_reg == ST_CONVERT) && !conv_done
		|=> state_reg == ST_CONVERT) else $error("trigger disturbed a running conversion");
	a_wake_delay: assert property ($rose(state_reg == ST_POWER_UP) |-> wait_cnt_reg == 12'h0 ##1
		(state_reg == ST_POWER_UP)[*8]) else $error("power-up delay cut short");
	a_mod_edge: assert property ($rose(mod_clk_reg) |-> div_cnt_reg == 9'h0)
		else $error("modulator clock not aligned to divider");

	c_single_done: cover property ((state_reg == ST_CONVERT) && conv_done && cfg_reg.single_shot);
	c_back_to_back: cover property (conv_done && chain_reg);
	c_trigger_busy: cover property ((state_reg == ST_CONVERT) && trig_req);

endmodule

// ---- verification/adcs_modulator_model.sv ----
// Behavioural analog core that turns routed pin levels into a modulator bitstream
`timescale 1ns/100ps
module adcs_modulator_model (
	input wire logic clk,
	input wire logic analog_power,
	input wire logic modulator_clock,
	input wire adcs_pkg::adcs_route_type route,
	input wire logic [3:0] pin_level,
	output logic mod_bit
);
	logic pos_level; // Level on the selected positive pin
	logic neg_level; // Negative pin, or ground when switched
	logic clk_seen; // Modulator clock one cycle ago

	initial begin
		mod_bit = 1'b0;
		clk_seen = 1'b0;
	end

	// Difference of the routed pins; a grounded negative always reads low
	assign pos_level = pin_level[route.positive_input];
	assign neg_level = route.neg_grounded ? 1'b0 : pin_level[route.negative_input];

	// One bit per modulator period; an unpowered core leaves a churning line, never a held value
	always @(posedge clk) begin
		clk_seen <= modulator_clock;
		if (!analog_power) begin
			mod_bit <= ~mod_bit;
		end else if (clk_seen && !modulator_clock) begin
			// Equal levels give a balanced stream, else full scale
			mod_bit <= (pos_level == neg_level) ? ~mod_bit : pos_level;
		end
	end
endmodule

// ---- verification/adcs_sequencer_test.sv ----
// Self-checking bench for the conversion sequencer
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin fail_count++; \
	$display("mismatch %s expected %h seen %h", nm, ex, got); end end
module adcs_sequencer_test;
	logic clk; // 100 MHz
	logic reset; // Asynchronous, active high
	logic [3:0] addr;
	logic [15:0] wr_data;
	logic wr_strobe;
	logic rd_strobe;
	logic [15:0] rd_data;
	logic mod_bit;
	logic modulator_clock;
	logic analog_power;
	adcs_pkg::adcs_route_type route;
	logic irq;
	logic [3:0] pin_level; // Analog pin levels seen by the core model
	logic rd_pending; // A read answer is due this cycle
	logic [15:0] exp_q[$]; // Expected read data, oldest first
	logic [15:0] msk_q[$]; // Bits of each read that matter
	string name_q[$]; // What each read looks at
	logic [15:0] m_exp;
	logic [15:0] m_msk;
	string m_name;
	int fail_count;
	int samples_checked;
	logic [31:0] seed; // Random state
	int cyc; // Cycles taken by the last wait
	time t_first; // First continuous completion

	adcs_sequencer #(.HAS_MUX(1'b1)) i_dut (.clk(clk), .reset(reset), .addr(addr), .wr_data(wr_data),
		.wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data), .mod_bit(mod_bit),
		.modulator_clock(modulator_clock), .analog_power(analog_power), .route(route), .irq(irq));
	adcs_modulator_model i_core (.clk(clk), .analog_power(analog_power), .modulator_clock(modulator_clock),
		.route(route), .pin_level(pin_level), .mod_bit(mod_bit));

	// ************************************************************
	// Bus tasks and helpers
	// ************************************************************
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	// One-cycle write strobe
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wr_data <= d;
		wr_strobe <= 1'b1;
		@(posedge clk);
		wr_strobe <= 1'b0;
	endtask

	// One-cycle read strobe; the answer is noted for the monitor
	task automatic rd(input logic [3:0] a, input logic [15:0] ex, input logic [15:0] m, input string nm);
		@(posedge clk);
		addr <= a;
		rd_strobe <= 1'b1;
		exp_q.push_back(ex);
		msk_q.push_back(m);
		name_q.push_back(nm);
		@(posedge clk);
		rd_strobe <= 1'b0;
	endtask

	// Bounded wait for irq (0), analog_power (1) or modulator_clock (2) to reach a level
	task automatic wait_level(input int which, input logic lvl, input int lim);
		logic s;
		cyc = 0;
		for (int i = 1; i <= lim; i++) begin
			@(posedge clk);
			s = (which == 0) ? irq : (which == 1) ? analog_power : modulator_clock;
			if (s === lvl) begin
				cyc = i;
				return;
			end
		end
		fail_count++;
		$display("mismatch wait %0d expected %h seen timeout", which, lvl);
		close_out();
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Read data stands only in the cycle after the strobe, so it is taken exactly there
	always @(posedge clk) begin
		rd_pending <= rd_strobe;
		if (rd_pending === 1'b1) begin
			m_msk = msk_q.pop_front();
			m_exp = exp_q.pop_front() & m_msk;
			m_name = name_q.pop_front();
			`CHK(m_name, m_exp, rd_data & m_msk)
		end
	end

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		reset = 1'b1;
		addr = 4'h0;
		wr_data = 16'h0;
		wr_strobe = 1'b0;
		rd_strobe = 1'b0;
		pin_level = 4'b0101;
		rd_pending = 1'b0;
		fail_count = 0;
		samples_checked = 0;
		seed = 32'hab92fc7b;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		// Reset leaves single-shot, powered down, rate code 4
		rd(adcs_pkg::CONFIG_OFFSET, 16'h8180, 16'hf1e0, "config");
		rd(adcs_pkg::MASK_OFFSET, 16'h0, 16'h1, "mask");
		`CHK("power", 1'b0, analog_power)
		// Modulator clock: 200 cycles high, 200 low
		wait_level(2, 1'b0, 500);
		wait_level(2, 1'b1, 300);
		wait_level(2, 1'b0, 300);
		`CHK("mod high", 200, cyc)
		wait_level(2, 1'b1, 300);
		`CHK("mod low", 200, cyc)
		// Unmapped places ignore writes and read zero
		for (int i = 0; i < 3; i++) begin
			seed = xorshift(seed);
			wr(seed[3:0] | 4'h1, seed[31:16]);
			rd(seed[3:0] | 4'h1, 16'h0, 16'hffff, "unmapped");
		end
		$display("test reset_and_clock done");
		// Single-shot, input 2 single-ended, fastest rate
		wr(adcs_pkg::CONFIG_OFFSET, 16'he1c0);
		repeat (2) @(posedge clk);
		`CHK("power", 1'b1, analog_power)
		repeat (3000) @(posedge clk);
		`CHK("route", adcs_pkg::adcs_route_type'{2'h2, 2'h0, 1'b1}, route)
		rd(adcs_pkg::CONFIG_OFFSET, 16'h0, 16'h8000, "busy flag");
		// A second trigger while converting must change nothing
		wr(adcs_pkg::CONFIG_OFFSET, 16'he1c0);
		wait_level(1, 1'b0, 40000);
		rd(adcs_pkg::RESULT_OFFSET, 16'h07ff, 16'h0fff, "result");
		rd(adcs_pkg::STATUS_OFFSET, 16'h1, 16'h1, "status");
		rd(adcs_pkg::CONFIG_OFFSET, 16'he1c0, 16'hf1e0, "config");
		repeat (50) @(posedge clk);
		`CHK("power", 1'b0, analog_power)
		`CHK("irq masked", 1'b0, irq)
		wr(adcs_pkg::MASK_OFFSET, 16'h1);
		repeat (2) @(posedge clk);
		`CHK("irq", 1'b1, irq)
		wr(adcs_pkg::STATUS_OFFSET, 16'h1);
		repeat (2) @(posedge clk);
		`CHK("irq cleared", 1'b0, irq)
		$display("test single_shot done");
		// Continuous, input 0 against input 3, then select changed mid-run
		// Pins kept: the leftover single-ended route gives the same bit, so the first sample is known
		wr(adcs_pkg::CONFIG_OFFSET, 16'h10c0);
		wait_level(0, 1'b1, 40000);
		t_first = $time;
		repeat (5) @(posedge clk);
		`CHK("route", adcs_pkg::adcs_route_type'{2'h0, 2'h3, 1'b0}, route)
		rd(adcs_pkg::RESULT_OFFSET, 16'h07ff, 16'h0fff, "result");
		wr(adcs_pkg::STATUS_OFFSET, 16'h1);
		wr(adcs_pkg::CONFIG_OFFSET, 16'h20c0);
		repeat (5) @(posedge clk);
		`CHK("route kept", adcs_pkg::adcs_route_type'{2'h0, 2'h3, 1'b0}, route)
		wait_level(0, 1'b1, 31000);
		`CHK("spacing", 300000, $time - t_first)
		repeat (5) @(posedge clk);
		`CHK("route new", adcs_pkg::adcs_route_type'{2'h1, 2'h3, 1'b0}, route)
		rd(adcs_pkg::RESULT_OFFSET, 16'h07ff, 16'h0fff, "result old select");
		repeat (3) @(posedge clk);
		$display("test continuous done");
		close_out();
	end
endmodule
